// *** hw/sample_packet_fifo_writer.sv ***
// Packet packer, 512-byte FIFO and APB register file for slot results
// Notes on behaviour
// - Subsampled and decimating slots at equal rates write in the same sequence.
// - Each packet holds, in slot order, only slots with output this period.
// - Decimating slots run every cycle; subsampled slots run only on output cycles.
// - Enabled status byte follows all slots in every packet that is written.
// - At period end write selected dark, lit and net values per slot.
// - Each value is shifted right by its own amount, 0 to 31.
// - Each value uses its byte count, 0 to 4; zero writes nothing.
// - Bits set above the chosen width saturate the value to all ones.
// - Within a slot, first channel values all precede second channel values.
// - Dark value precedes net value.
// - Byte order: 15:8, 7:0, then 31:24, 23:16 as size allows.
// - Write only if space exists for every active slot.
// - Packet that does not fit is dropped whole and overrun flagged.
// - 512-byte FIFO; empty read returns ff and flags underrun.
// - Dark and net results: internal copy per sample, latched copy for host.
// - Hold bit freezes the latched copy; clearing it resumes updates.
// - Subsampled slot runs once every factor-plus-one cycles.
// - Net equals lit minus dark when the decimated value is ready.
`timescale 1ns/1ps
module sample_packet_fifo_writer
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [sample_fifo_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  periodStart,
    input  wire logic                  periodEnd,
    input  wire logic                  resValid,
    input  wire logic [3:0]            resSlot,
    input  wire logic                  resChan,
    input  wire logic [31:0]           resDark,
    input  wire logic [31:0]           resLit,
    output logic [sample_fifo_pkg::NSLOT-1:0] slotRun,
    output logic                       writerBusy
);
    import sample_fifo_pkg::*;

    logic [31:0]      cfgA     [NSLOT];
    logic [31:0]      cfgB     [NSLOT];
    logic [31:0]      accDark  [NSLOT][NCH];
    logic [31:0]      accLit   [NSLOT][NCH];
    logic [31:0]      outDark  [NSLOT][NCH];
    logic [31:0]      outLit   [NSLOT][NCH];
    logic [31:0]      outNet   [NSLOT][NCH];
    logic [31:0]      hostDark [NSLOT][NCH];
    logic [31:0]      hostNet  [NSLOT][NCH];
    logic [FAC_W-1:0] phase    [NSLOT];
    logic [NSLOT-1:0] readyNow;
    logic [NSLOT-1:0] readyVec;
    logic [NSLOT-1:0] holdRegs;
    logic             statusEn;
    logic             overrunFlag;
    logic             underrunFlag;
    logic [7:0]       mem      [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] needBytes;
    logic [CNT_W-1:0] freeBytes;
    wstate_t          wState;
    logic [3:0]       wS;
    logic             wC;
    logic [1:0]       wF;
    logic [1:0]       wB;
    logic             curValid;
    logic [7:0]       curByte;
    logic             lastStep;
    logic             pushEn;
    logic             popEn;
    logic             setupRd;
    logic             accessWr;
    logic [31:0]      next_prdata;
    logic             mapped;

    function automatic logic [FAC_W-1:0] factorOf(input logic [31:0] c);
        return c[CFG_FAC +: FAC_W];
    endfunction : factorOf

    function automatic logic [SZ_W-1:0] sizeOf(input logic [31:0] c, input logic [1:0] f);
        unique case (f)
            2'd0:    return c[CFG_DSZ +: SZ_W];
            2'd1:    return c[CFG_LSZ +: SZ_W];
            default: return c[CFG_NSZ +: SZ_W];
        endcase
    endfunction : sizeOf

    function automatic logic [SH_W-1:0] shiftOf(input logic [31:0] c, input logic [1:0] f);
        unique case (f)
            2'd0:    return c[SH_D +: SH_W];
            2'd1:    return c[SH_L +: SH_W];
            default: return c[SH_N +: SH_W];
        endcase
    endfunction : shiftOf

    // Shift, saturate and pick one byte in emission order
    function automatic logic [7:0] packByte(input logic [31:0] v, input logic [SH_W-1:0] sh,
                                            input logic [SZ_W-1:0] sz, input logic [1:0] idx);
        logic [31:0] s;
        logic [31:0] lim;
        logic [1:0]  lane;
        s = v >> sh;
        lim = (sz >= SZ_W'(MAX_BYTES)) ? 32'hffff_ffff : ((32'h1 << (8 * sz)) - 32'h1);
        if (s > lim)
            s = lim;
        if (sz == SZ_W'(1))
            lane = 2'd0;
        else if (sz == SZ_W'(3) && idx == 2'd2)
            lane = 2'd2;
        else
            lane = idx ^ 2'd1;
        return s[8 * lane +: 8];
    endfunction : packByte

    // Decimation phase and run enables
    always_comb
    begin
        for (int s = 0; s < NSLOT; s++)
            readyNow[s] = cfgA[s][CFG_EN] && (phase[s] == factorOf(cfgA[s]));
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            slotRun <= '0;
            for (int s = 0; s < NSLOT; s++)
                phase[s] <= '0;
        end
        else
        begin
            if (periodStart)
            begin
                for (int s = 0; s < NSLOT; s++)
                    slotRun[s] <= cfgA[s][CFG_EN] && (!cfgA[s][CFG_SUB] || readyNow[s]);
            end
            if (periodEnd)
            begin
                for (int s = 0; s < NSLOT; s++)
                    phase[s] <= (!cfgA[s][CFG_EN] || readyNow[s]) ? '0 : phase[s] + FAC_W'(1);
            end
        end
    end

    // Block-sum accumulation and result registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            readyVec <= '0;
            for (int s = 0; s < NSLOT; s++)
                for (int c = 0; c < NCH; c++)
                begin
                    accDark[s][c] <= '0;
                    accLit[s][c] <= '0;
                    outDark[s][c] <= '0;
                    outLit[s][c] <= '0;
                    outNet[s][c] <= '0;
                    hostDark[s][c] <= '0;
                    hostNet[s][c] <= '0;
                end
        end
        else
        begin
            if (resValid && resSlot < 4'(NSLOT))
            begin
                accDark[resSlot][resChan] <= accDark[resSlot][resChan] + resDark;
                accLit[resSlot][resChan] <= accLit[resSlot][resChan] + resLit;
            end
            if (periodEnd)
            begin
                readyVec <= readyNow;
                for (int s = 0; s < NSLOT; s++)
                    if (readyNow[s])
                        for (int c = 0; c < NCH; c++)
                        begin
                            accDark[s][c] <= '0;
                            accLit[s][c] <= '0;
                            outDark[s][c] <= accDark[s][c];
                            outLit[s][c] <= accLit[s][c];
                            outNet[s][c] <= accLit[s][c] - accDark[s][c];
                            if (!holdRegs[s])
                            begin
                                hostDark[s][c] <= accDark[s][c];
                                hostNet[s][c] <= accLit[s][c] - accDark[s][c];
                            end
                        end
            end
        end
    end

    // Space needed by every active slot, ready or not
    always_comb
    begin
        needBytes = statusEn ? CNT_W'(1) : '0;
        for (int s = 0; s < NSLOT; s++)
            if (cfgA[s][CFG_EN])
                needBytes = needBytes + ((CNT_W'(sizeOf(cfgA[s], 2'd0))
                            + CNT_W'(sizeOf(cfgA[s], 2'd1))
                            + CNT_W'(sizeOf(cfgA[s], 2'd2))) << cfgA[s][CFG_CH2]);
        freeBytes = CNT_W'(FIFO_DEPTH) - count;
    end

    // Packet walker: slot, channel, field, byte
    always_comb
    begin
        curValid = (wState == W_WRITE) && readyVec[wS] && cfgA[wS][CFG_EN]
                   && (!wC || cfgA[wS][CFG_CH2])
                   && ({1'b0, wB} < sizeOf(cfgA[wS], wF));
        unique case (wF)
            2'd0:    curByte = packByte(outDark[wS][wC], shiftOf(cfgB[wS], wF),
                                        sizeOf(cfgA[wS], wF), wB);
            2'd1:    curByte = packByte(outLit[wS][wC], shiftOf(cfgB[wS], wF),
                                        sizeOf(cfgA[wS], wF), wB);
            default: curByte = packByte(outNet[wS][wC], shiftOf(cfgB[wS], wF),
                                        sizeOf(cfgA[wS], wF), wB);
        endcase
        if (wState == W_STAT)
            curByte = {6'h00, underrunFlag, overrunFlag};
        lastStep = (wS == 4'(NSLOT - 1)) && wC && (wF == 2'd2) && (wB == 2'd3);
        pushEn = curValid || (wState == W_STAT);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wState <= W_IDLE;
            wS <= '0;
            wC <= 1'b0;
            wF <= '0;
            wB <= '0;
            writerBusy <= 1'b0;
        end
        else
        begin
            unique case (wState)
                W_IDLE:
                begin
                    if (periodEnd && needBytes != '0 && needBytes <= freeBytes)
                    begin
                        wState <= W_WRITE;
                        writerBusy <= 1'b1;
                    end
                    wS <= '0;
                    wC <= 1'b0;
                    wF <= '0;
                    wB <= '0;
                end
                W_WRITE:
                begin
                    wB <= wB + 2'd1;
                    if (wB == 2'd3)
                    begin
                        wF <= (wF == 2'd2) ? 2'd0 : wF + 2'd1;
                        if (wF == 2'd2)
                        begin
                            wC <= ~wC;
                            if (wC)
                                wS <= wS + 4'd1;
                        end
                    end
                    if (lastStep)
                    begin
                        wState <= statusEn ? W_STAT : W_IDLE;
                        writerBusy <= statusEn;
                    end
                end
                W_STAT:
                begin
                    wState <= W_IDLE;
                    writerBusy <= 1'b0;
                end
                default:
                begin
                    wState <= W_IDLE;
                    writerBusy <= 1'b0;
                end
            endcase
        end
    end

    // FIFO storage and pointers
    always_ff @(posedge clk)
    begin
        if (pushEn)
            mem[wrPtr] <= curByte;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (pushEn)
                wrPtr <= wrPtr + PTR_W'(1);
            if (popEn)
                rdPtr <= rdPtr + PTR_W'(1);
            count <= count + CNT_W'(pushEn) - CNT_W'(popEn);
        end
    end

    // APB decode
    always_comb
    begin
        setupRd = psel && !penable && !pready && !pwrite;
        accessWr = psel && penable && pready && pwrite;
        popEn = setupRd && (paddr == REG_DATA) && (count != '0);
        mapped = (paddr == REG_CTRL) || (paddr == REG_HOLD) || (paddr == REG_STATUS)
                 || (paddr == REG_DATA)
                 || (paddr >= REG_CFG_BASE && paddr < REG_CFG_END && paddr[1:0] == 2'b00)
                 || (paddr >= REG_RES_BASE && paddr < REG_RES_END && paddr[1:0] == 2'b00);
        next_prdata = WORD_ZERO;
        if (paddr == REG_CTRL)
            next_prdata[CTRL_STATEN] = statusEn;
        else if (paddr == REG_HOLD)
            next_prdata[NSLOT-1:0] = holdRegs;
        else if (paddr == REG_STATUS)
        begin
            next_prdata[CNT_W-1:0] = count;
            next_prdata[STAT_OVR] = overrunFlag;
            next_prdata[STAT_UNR] = underrunFlag;
        end
        else if (paddr == REG_DATA)
            next_prdata[7:0] = (count == '0) ? EMPTY_BYTE : mem[rdPtr];
        else if (mapped && paddr < REG_CFG_END)
            next_prdata = paddr[2] ? cfgB[paddr[6:3] - 4'h0] : cfgA[paddr[6:3]];
        else if (mapped)
            next_prdata = paddr[2] ? hostNet[paddr[7:4]][paddr[3]]
                                   : hostDark[paddr[7:4]][paddr[3]];
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !mapped;
            if (setupRd)
                prdata <= next_prdata;
        end
    end

    // Software-written control state
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            statusEn <= 1'b0;
            holdRegs <= '0;
            for (int s = 0; s < NSLOT; s++)
            begin
                cfgA[s] <= '0;
                cfgB[s] <= '0;
            end
        end
        else if (accessWr && mapped)
        begin
            if (paddr == REG_CTRL)
                statusEn <= pwdata[CTRL_STATEN];
            else if (paddr == REG_HOLD)
                holdRegs <= pwdata[NSLOT-1:0];
            else if (paddr >= REG_CFG_BASE && paddr < REG_CFG_END)
            begin
                if (paddr[2])
                    cfgB[paddr[6:3]] <= pwdata;
                else
                    cfgA[paddr[6:3]] <= pwdata;
            end
        end
    end

    // Sticky flags, set wins over write-one-to-clear
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            overrunFlag <= 1'b0;
            underrunFlag <= 1'b0;
        end
        else
        begin
            if (periodEnd && wState == W_IDLE && needBytes > freeBytes)
                overrunFlag <= 1'b1;
            else if (accessWr && paddr == REG_STATUS && pwdata[STAT_OVR])
                overrunFlag <= 1'b0;
            if (setupRd && paddr == REG_DATA && count == '0)
                underrunFlag <= 1'b1;
            else if (accessWr && paddr == REG_STATUS && pwdata[STAT_UNR])
                underrunFlag <= 1'b0;
        end
    end
endmodule : sample_packet_fifo_writer

// *** hw/sample_fifo_pkg.sv ***
// Constants, register map and types for the sample packet FIFO writer
package sample_fifo_pkg;
    localparam int NSLOT = 12;
    localparam int NCH = 2;
    localparam int NFLD = 3;
    localparam int FIFO_DEPTH = 512;
    localparam int PTR_W = 9;
    localparam int CNT_W = 10;
    localparam int ADDR_W = 12;
    localparam int SZ_W = 3;
    localparam int SH_W = 5;
    localparam int FAC_W = 11;
    localparam int MAX_BYTES = 4;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_HOLD = 12'h004;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] REG_DATA = 12'h00c;
    localparam logic [ADDR_W-1:0] REG_CFG_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] REG_CFG_END = 12'h160;
    localparam logic [ADDR_W-1:0] REG_RES_BASE = 12'h200;
    localparam logic [ADDR_W-1:0] REG_RES_END = 12'h2c0;
    // Slot config word 0 fields
    localparam int CFG_EN = 0;
    localparam int CFG_SUB = 1;
    localparam int CFG_CH2 = 2;
    localparam int CFG_DSZ = 3;
    localparam int CFG_LSZ = 6;
    localparam int CFG_NSZ = 9;
    localparam int CFG_FAC = 12;
    // Slot config word 1 fields
    localparam int SH_D = 0;
    localparam int SH_L = 5;
    localparam int SH_N = 10;
    // Control and status fields
    localparam int CTRL_STATEN = 0;
    localparam int STAT_OVR = 16;
    localparam int STAT_UNR = 17;
    localparam logic [7:0] EMPTY_BYTE = 8'hff;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    typedef enum logic [2:0] {
        W_IDLE  = 3'b001,
        W_WRITE = 3'b010,
        W_STAT  = 3'b100
    } wstate_t;
endpackage : sample_fifo_pkg

// *** tb/sample_packet_fifo_writer_monitor.sv ***
// Port checker for the sample packet FIFO writer
`timescale 1ns/1ps
module sample_packet_fifo_writer_monitor
(
    input wire logic                           clk,
    input wire logic                           rstn,
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic [sample_fifo_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                    prdata,
    input wire logic                           pready,
    input wire logic                           pslverr,
    input wire logic                           periodStart,
    input wire logic                           periodEnd,
    input wire logic [sample_fifo_pkg::NSLOT-1:0] slotRun,
    input wire logic                           writerBusy
);
    import sample_fifo_pkg::*;
    logic [9:0] busyCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Length of the current writer run
    always_ff @(posedge clk)
        busyCnt <= (!rstn || !writerBusy) ? 10'h000 : busyCnt + 10'h001;
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("answer without setup");
    ready_phase_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("answer outside one access cycle");
    bad_addr_a: assert property (psel && !penable && (paddr[1:0] != 2'h0 || paddr == 12'h010)
        |=> pslverr) else $error("bad address not refused");
    err_gate_a: assert property (pslverr |-> pready)
        else $error("error without answer");
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    run_edge_a: assert property (!$stable(slotRun) |-> $past(periodStart))
        else $error("slot run changed off period start");
    busy_cause_a: assert property ($rose(writerBusy) |-> $past(periodEnd))
        else $error("writer started without period end");
    busy_len_a: assert property ($fell(writerBusy) |-> busyCnt inside {[287:291]})
        else $error("writer run length wrong");
endmodule : sample_packet_fifo_writer_monitor

bind sample_packet_fifo_writer sample_packet_fifo_writer_monitor mon (.clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .periodStart, .periodEnd,
    .slotRun, .writerBusy);

// *** tb/slot_result_source.sv ***
// Upstream sequencer model producing one sampling period per kick
`timescale 1ns/1ps
module slot_result_source
(
    input  wire logic                             clk,
    input  wire logic                             rstn,
    input  wire logic                             kick,
    input  wire logic [sample_fifo_pkg::NSLOT-1:0] slotRun,
    input  wire logic [31:0]                      dIn,
    input  wire logic [31:0]                      lIn,
    output logic                                  periodStart,
    output logic                                  periodEnd,
    output logic                                  resValid,
    output logic [3:0]                            resSlot,
    output logic                                  resChan,
    output logic [31:0]                           resDark,
    output logic [31:0]                           resLit,
    output logic                                  ready
);
    import sample_fifo_pkg::*;
    logic [8:0] cnt;
    logic [3:0] slot;
    assign slot = 4'((cnt - 9'h002) >> 1);
    always_ff @(posedge clk)
    begin
        periodStart <= 1'b0;
        periodEnd   <= 1'b0;
        resValid    <= 1'b0;
        resDark     <= ~resDark;
        resLit      <= ~resLit;
        cnt         <= cnt + 9'h001;
        if (!rstn)
        begin
            ready   <= 1'b1;
            resDark <= 32'h0;
            resLit  <= 32'h0;
        end
        else if (ready)
        begin
            cnt         <= 9'h000;
            ready       <= !kick;
            periodStart <= kick;
        end
        else
        begin
            if (cnt >= 9'h002 && cnt < 9'h01a && slotRun[slot])
            begin
                resValid <= 1'b1;
                resSlot  <= slot;
                resChan  <= cnt[0];
                resDark  <= dIn;
                resLit   <= lIn;
            end
            periodEnd <= (cnt == 9'h01a);
            ready     <= (cnt == 9'h14a);
        end
    end
endmodule : slot_result_source

// *** tb/tb_sample_packet_fifo_writer.sv ***
// Self-checking bench for the sample packet FIFO writer
`timescale 1ns/1ps
module tb_sample_packet_fifo_writer;
    import sample_fifo_pkg::*;
    logic clk, rstn, psel, penable, pwrite, kick, ready, pready, pslverr, perr;
    logic periodStart, periodEnd, resValid, resChan, writerBusy;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, resDark, resLit, dIn, lIn, rd;
    logic [3:0] resSlot;
    logic [NSLOT-1:0] slotRun;
    logic [31:0] cfgA [4] = '{32'h8d5, 32'h100b, 32'h1821, 32'h209};
    logic [31:0] cfgB [4] = '{32'h404, 32'h0, 32'h0, 32'h1f};
    logic [7:0] expq [$];
    int error_cnt, checks, per;

    sample_packet_fifo_writer dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .periodStart, .periodEnd, .resValid, .resSlot,
        .resChan, .resDark, .resLit, .slotRun, .writerBusy);
    slot_result_source src (.clk, .rstn, .kick, .slotRun, .dIn, .lIn, .periodStart,
        .periodEnd, .resValid, .resSlot, .resChan, .resDark, .resLit, .ready);

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim;
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1 && ++n < 20);
        rd   = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            chk("apb ready", 32'h1, 32'h0);
            end_sim();
        end
    endtask : apb

    task automatic push(input logic [31:0] v, input int sh, input int sz);
        logic [31:0] x;
        x = v >> sh;
        if (sz < 4 && (x >> (8 * sz)) != 0)
            x = (32'h1 << (8 * sz)) - 32'h1;
        if (sz > 1)
            expq.push_back(x[15:8]);
        if (sz > 0)
            expq.push_back(x[7:0]);
        if (sz > 3)
            expq.push_back(x[31:24]);
        if (sz > 2)
            expq.push_back(x[23:16]);
    endtask : push

    task automatic period(input bit drop);
        int n = 0;
        logic [NSLOT-1:0] run;
        logic [31:0] c, k, d, l;
        per++;
        run = '0;
        for (int s = 0; s < 4; s++)
        begin
            c = cfgA[s];
            k = c[CFG_FAC +: FAC_W] + 1;
            run[s] = !c[CFG_SUB] || per % k == 0;
            d = c[CFG_SUB] ? dIn : dIn * k;
            l = c[CFG_SUB] ? lIn : lIn * k;
            for (int ch = 0; ch <= int'(c[CFG_CH2]) && per % k == 0 && !drop; ch++)
            begin
                push(d, cfgB[s][SH_D +: SH_W], c[CFG_DSZ +: SZ_W]);
                push(l, cfgB[s][SH_L +: SH_W], c[CFG_LSZ +: SZ_W]);
                push(l - d, cfgB[s][SH_N +: SH_W], c[CFG_NSZ +: SZ_W]);
            end
        end
        if (!drop)
            expq.push_back(8'h00);
        @(posedge clk);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        do
            @(posedge clk);
        while (ready !== 1'b1 && ++n < 1000);
        if (n == 1000)
        begin
            chk("period ready", 32'h1, 32'h0);
            end_sim();
        end
        chk("slot run", 32'(run), 32'(slotRun));
    endtask : period

    task automatic drain(input int m);
        for (int i = 0; i < m && expq.size() > 0; i++)
        begin
            apb(1'b0, REG_DATA, WORD_ZERO);
            chk("fifo byte", {24'h0, expq.pop_front()}, rd);
        end
    endtask : drain

    task automatic res(input logic [31:0] d, input logic [31:0] l);
        apb(1'b0, REG_RES_BASE, WORD_ZERO);
        chk("dark reg", d, rd);
        apb(1'b0, REG_RES_BASE + 12'h004, WORD_ZERO);
        chk("net reg", l - d, rd);
    endtask : res

    task automatic stat(input logic [9:0] c, input logic [1:0] f);
        apb(1'b0, REG_STATUS, WORD_ZERO);
        chk("status", {14'h0, f, 6'h0, c}, rd);
    endtask : stat

    initial
    begin
        {rstn, psel, penable, pwrite, kick} = 5'h00;
        paddr = '0;
        pwdata = WORD_ZERO;
        dIn = 32'h0001_2345;
        lIn = 32'h8765_4321;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        stat(10'h000, 2'h0);
        apb(1'b0, 12'h010, WORD_ZERO);
        chk("unmapped", 32'h1, 32'(perr));
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, REG_CFG_BASE + 12'(8 * s), cfgA[s]);
            apb(1'b1, REG_CFG_BASE + 12'(8 * s + 4), cfgB[s]);
        end
        apb(1'b1, REG_CTRL, 32'h1);
        period(1'b0);
        drain(999);
        apb(1'b0, REG_DATA, WORD_ZERO);
        chk("empty byte", 32'h0000_00ff, rd);
        stat(10'h000, 2'h2);
        apb(1'b1, REG_STATUS, 32'h0003_0000);
        period(1'b0);
        drain(999);
        res(dIn, lIn);
        apb(1'b1, REG_HOLD, 32'h1);
        dIn = 32'h0000_0100;
        lIn = 32'h0012_0300;
        period(1'b0);
        res(32'h0001_2345, 32'h8765_4321);
        apb(1'b1, REG_HOLD, WORD_ZERO);
        period(1'b0);
        res(dIn, lIn);
        drain(999);
        repeat (20) period(1'b0);
        stat(10'h1fe, 2'h0);
        drain(23);
        period(1'b1);
        stat(10'h1e7, 2'h1);
        drain(999);
        stat(10'h000, 2'h1);
        end_sim();
    end
endmodule : tb_sample_packet_fifo_writer
